// *** inc/sadc_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------
// serial converter register access: shared constants
// ----------------------------------------------------------------
package sadc_pkg;
   // frame and register widths
   localparam int           W_FRAME     = 16;
   localparam int           W_DATA      = 14;
   localparam logic [3:0]   LAST_BIT    = 4'hf;
   // write address field (two leading bits of a frame)
   localparam logic [1:0]   ADDR_NONE   = 2'h0;
   localparam logic [1:0]   ADDR_TEST   = 2'h1;
   localparam logic [1:0]   ADDR_CAL    = 2'h2;
   localparam logic [1:0]   ADDR_CTRL   = 2'h3;
   // read target codes
   localparam logic [1:0]   RD_CONV     = 2'h0;
   localparam logic [1:0]   RD_TEST     = 2'h1;
   localparam logic [1:0]   RD_CAL      = 2'h2;
   localparam logic [1:0]   RD_STAT     = 2'h3;
   // control word field positions
   localparam int           B_PM_HI     = 9;
   localparam int           B_PM_LO     = 8;
   localparam int           B_RD_HI     = 7;
   localparam int           B_RD_LO     = 6;
   localparam int           B_MODE      = 5;
   localparam int           B_CONV      = 4;
   localparam int           B_CAL_FAM   = 3;
   localparam int           B_CSEL_HI   = 2;
   localparam int           B_CSEL_LO   = 1;
   localparam int           B_CAL_START = 0;
   // reset values
   localparam logic [13:0]  CTRL_RST    = 14'h0000;
   localparam logic [13:0]  TEST_RST    = 14'h0000;
   localparam logic [13:0]  CAL_RST     = 14'h0000;
   // calibration coefficient store: gain, offset, eight dac words
   localparam int           CAL_N       = 10;
   localparam logic [3:0]   IDX_GAIN    = 4'h0;
   localparam logic [3:0]   IDX_OFFS    = 4'h1;
   localparam logic [3:0]   IDX_DAC_END = 4'h9;
   // calibration selector codes
   localparam logic [1:0]   CSEL_FULL   = 2'h0;
   localparam logic [1:0]   CSEL_G_O    = 2'h1;
   localparam logic [1:0]   CSEL_OFFS   = 2'h2;
   localparam logic [1:0]   CSEL_GAIN   = 2'h3;
endpackage
`default_nettype wire

// *** inc/sadc_ser_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// word level link between serial shifter and register logic
// ----------------------------------------------------------------
interface sadc_ser_if;
   logic        word_done;
   logic [15:0] rx_word;
   logic [15:0] tx_word;
   logic        tx_bit;
   logic        tx_active;
   modport shifter (output word_done, output rx_word, output tx_bit,
                    output tx_active, input tx_word);
   modport regs    (input word_done, input rx_word, input tx_bit,
                    input tx_active, output tx_word);
endinterface
`default_nettype wire

// *** hdl/sadc_shift.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// serial frame shifter, msb first, sclk sampled by i_clk
// ----------------------------------------------------------------
module sadc_shift
   import sadc_pkg::*;
(
   input  wire logic  i_clk,
   input  wire logic  i_nrst,
   input  wire logic  i_sclk,
   input  wire logic  i_sync_n,
   input  wire logic  i_din,
   sadc_ser_if.shifter bus
);
   logic [2:0]  s_sclk;
   logic [2:0]  s_sync;
   logic [1:0]  s_din;
   logic [3:0]  cnt;
   logic [15:0] rx;
   logic [15:0] tx;
   logic        active;
   logic        done;
   wire         rise   = s_sclk[1] & ~s_sclk[2];
   wire         fall   = ~s_sclk[1] & s_sclk[2];
   wire         fstart = ~s_sync[1] & s_sync[2];

   // pin synchronisers; stage 0 feeds stage 1 only
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s_sclk <= 3'h0;
         s_sync <= 3'h7;
         s_din  <= 2'h0;
      end else begin
         s_sclk <= {s_sclk[1:0], i_sclk};
         s_sync <= {s_sync[1:0], i_sync_n};
         s_din  <= {s_din[0], i_din};
      end
   end

   // shift in on rising sclk, out on falling; a frame cut short by
   // sync going high is dropped without a done pulse
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt    <= 4'h0;
         rx     <= 16'h0000;
         tx     <= 16'h0000;
         active <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (fstart) begin
            cnt    <= 4'h0;
            tx     <= bus.tx_word;
            active <= 1'b1;
         end else if (s_sync[1]) begin
            active <= 1'b0;                                // RULE_02
         end else if (active && rise) begin
            rx  <= {rx[14:0], s_din[1]};                   // RULE_21
            cnt <= cnt + 4'h1;
            if (cnt == LAST_BIT) begin
               done   <= 1'b1;                             // RULE_01
               active <= 1'b0;
            end
         end else if (active && fall && cnt != 4'h0) begin
            tx <= {tx[14:0], 1'b0};                        // RULE_21
         end
      end
   end

   assign bus.word_done = done;
   assign bus.rx_word   = rx;
   assign bus.tx_bit    = tx[15];
   assign bus.tx_active = active;
endmodule
`default_nettype wire

// *** hdl/sadc_calreg.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// calibration coefficient store with auto-stepping pointer
// ----------------------------------------------------------------
module sadc_calreg
   import sadc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic [1:0]  i_sel,
   input  wire logic        i_restart,
   input  wire logic        i_host_we,
   input  wire logic        i_host_re,
   input  wire logic [13:0] i_wdata,
   input  wire logic        i_core_we,
   input  wire logic [3:0]  i_core_idx,
   input  wire logic [13:0] i_core_data,
   output logic      [13:0] o_rdata,
   output logic      [3:0]  o_idx
);
   logic [13:0] mem [CAL_N];
   logic [3:0]  ptr;

   // first and last entry of the group a selector addresses
   function automatic logic [3:0] first_idx(input logic [1:0] s);
      first_idx = (s == CSEL_OFFS) ? IDX_OFFS : IDX_GAIN;
   endfunction
   function automatic logic [3:0] last_idx(input logic [1:0] s);
      case (s)
         CSEL_FULL: last_idx = IDX_DAC_END;
         CSEL_G_O:  last_idx = IDX_OFFS;
         CSEL_OFFS: last_idx = IDX_OFFS;
         default:   last_idx = IDX_GAIN;
      endcase
   endfunction

   // one word per entry; the calibration engine wins over the host
   generate
      for (genvar i = 0; i < CAL_N; i++) begin : g_ent
         wire core_hit = i_core_we && i_core_idx == 4'(i);
         wire host_hit = i_host_we && ptr == 4'(i);
         always_ff @(posedge i_clk) begin
            if (!i_nrst)
               mem[i] <= CAL_RST;
            else if (core_hit)
               mem[i] <= i_core_data;
            else if (host_hit)
               mem[i] <= i_wdata;                          // RULE_17
         end
      end
   endgenerate

   // pointer restarts on every control write, steps after each access
   always_ff @(posedge i_clk) begin
      if (!i_nrst)
         ptr <= IDX_GAIN;
      else if (i_restart)
         ptr <= first_idx(i_sel);                          // RULE_17
      else if (i_host_we || i_host_re)
         ptr <= (ptr == last_idx(i_sel)) ? first_idx(i_sel) : ptr + 4'h1;
   end

   assign o_rdata = mem[ptr];
   assign o_idx   = ptr;
endmodule
`default_nettype wire

// *** hdl/sadc_regs.sv ***
//Behaviour
//(RULE_01) a write frame is 16 bits: 2 address bits then 14 data bits
//(RULE_02) addressed register updates only after the sixteenth bit; partial frames change nothing
//(RULE_03) address 00 discards, 01 test, 10 selected calibration, 11 control word
//(RULE_04) read target sits in control bits 7:6, reset 00
//(RULE_05) read target 00 result, 01 test, 10 calibration, 11 status
//(RULE_06) reads keep coming from the chosen register until the target changes
//(RULE_07) result reads carry two leading zero bits
//(RULE_08) control word is 14 bits, write only, address 11, reset zero
//(RULE_09) host writes zeros into control bits 13:10
//(RULE_10) bits 9:8 with the sleep pin pick the power-down mode
//(RULE_11) bit 5 picks interface mode; 1 makes the data input pin drive too
//(RULE_12) interface mode bit clears after every read cycle
//(RULE_13) host in mode 1 sets the mode bit on every write
//(RULE_14) bit 4 starts one conversion and clears when it completes
//(RULE_15) bit 3 picks self calibration (0) or system calibration (1)
//(RULE_16) start bit 0 with bits 2:1 and bit 3 picks calibration; clears at end
//(RULE_17) with start bit 0, bits 2:1 address the coefficient registers
//(RULE_18) self selectors: 00 dac gain offset, 01 gain offset, 10 offset, 11 gain
//(RULE_19) system selectors: same order using system gain and offset
//(RULE_20) result and status read only; test and calibration read and write
//(RULE_21) words shift most significant bit first
`timescale 1ns/10ps
`default_nettype none
module sadc_regs
   import sadc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_sclk,
   input  wire logic        i_sync_n,
   input  wire logic        i_din,
   input  wire logic        i_sleep_n,
   input  wire logic [13:0] i_conv_data,
   input  wire logic        i_conv_done,
   input  wire logic        i_cal_done,
   input  wire logic        i_core_cal_we,
   input  wire logic [3:0]  i_core_cal_idx,
   input  wire logic [13:0] i_core_cal_data,
   output logic             o_dout,
   output logic             o_din_out,
   output logic             o_din_oe_n,
   output logic             o_conv_start,
   output logic             o_cal_start,
   output logic      [2:0]  o_cal_type,
   output logic      [3:0]  o_cal_idx,
   output logic      [2:0]  o_power_sel,
   output logic             o_busy
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sadc_ser_if  ser ();
   logic [13:0] ctrl;
   logic [13:0] test;
   logic [1:0]  s_sleep;
   logic        ctrl_wr_q;
   logic [13:0] cal_rdata;

   // ----------------------------------------------------------------
   // serial shifter and coefficient store
   // ----------------------------------------------------------------
   sadc_shift u_shift (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_sclk   (i_sclk),
      .i_sync_n (i_sync_n),
      .i_din    (i_din),
      .bus      (ser.shifter)
   );

   // ----------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------
   // address and data split of a completed frame
   wire [1:0]  wr_addr  = ser.rx_word[15:14];                         // RULE_01
   wire [13:0] wr_data  = ser.rx_word[13:0];
   wire        done     = ser.word_done;
   wire        wr_ctrl  = done && wr_addr == ADDR_CTRL;                // RULE_03
   wire        wr_test  = done && wr_addr == ADDR_TEST;                // RULE_03
   wire        wr_cal   = done && wr_addr == ADDR_CAL;                 // RULE_03
   wire [1:0]  rd_sel   = ctrl[B_RD_HI:B_RD_LO];                       // RULE_04
   wire        rd_cal   = done && rd_sel == RD_CAL;
   wire        mode1    = ctrl[B_MODE];
   wire        busy     = ctrl[B_CONV] | ctrl[B_CAL_START];
   // new start requests, only when software writes a one
   wire        conv_req = wr_ctrl && wr_data[B_CONV];                  // RULE_14
   wire        cal_req  = wr_ctrl && wr_data[B_CAL_START];             // RULE_16

   sadc_calreg u_cal (
      .i_clk       (i_clk),
      .i_nrst      (i_nrst),
      .i_sel       (ctrl[B_CSEL_HI:B_CSEL_LO]),
      .i_restart   (ctrl_wr_q),
      .i_host_we   (wr_cal),
      .i_host_re   (rd_cal),
      .i_wdata     (wr_data),
      .i_core_we   (i_core_cal_we),
      .i_core_idx  (i_core_cal_idx),
      .i_core_data (i_core_cal_data),
      .o_rdata     (cal_rdata),
      .o_idx       (o_cal_idx)
   );

   // ----------------------------------------------------------------
   // read word selection
   // ----------------------------------------------------------------
   // status mirrors the control fields except bits 13:10 and 4, read target always reads 11
   wire [15:0] stat_word = {1'b0, busy, 4'h0,
                            ctrl[B_PM_HI:B_PM_LO], RD_STAT,
                            ctrl[B_MODE], 1'b0,
                            ctrl[B_CAL_FAM:B_CAL_START]};
   // loaded by the shifter at frame start; narrow words lead with zeros
   assign ser.tx_word =
      (rd_sel == RD_CONV) ? {2'h0, i_conv_data} :                      // RULE_07
      (rd_sel == RD_TEST) ? {2'h0, test} :                             // RULE_05
      (rd_sel == RD_CAL)  ? {2'h0, cal_rdata} :                        // RULE_05
                            stat_word;                                 // RULE_06

   // ----------------------------------------------------------------
   // control word
   // ----------------------------------------------------------------
   // a write frame beats the self-clearing events in the same cycle, so a
   // fresh start bit is never lost; a control write also ends the read cycle
   // but carries the host's own mode bit
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl <= CTRL_RST;                                             // RULE_08
      end else if (wr_ctrl) begin
         ctrl <= wr_data;                                              // RULE_02
      end else begin
         if (done)
            ctrl[B_MODE] <= 1'b0;                                      // RULE_12
         if (i_conv_done)
            ctrl[B_CONV] <= 1'b0;                                      // RULE_14
         if (i_cal_done)
            ctrl[B_CAL_START] <= 1'b0;                                 // RULE_16
      end
   end

   // test register; host should leave it alone but it is writable
   always_ff @(posedge i_clk) begin
      if (!i_nrst)
         test <= TEST_RST;
      else if (wr_test)
         test <= wr_data;                                              // RULE_20
   end

   // ----------------------------------------------------------------
   // core requests and sleep pin
   // ----------------------------------------------------------------
   // single-cycle start pulses; calibration type is bit 3 with bits 2:1
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_conv_start <= 1'b0;
         o_cal_start  <= 1'b0;
         o_cal_type   <= 3'h0;
         ctrl_wr_q    <= 1'b0;
         s_sleep      <= 2'h3;
      end else begin
         o_conv_start <= conv_req;                                     // RULE_14
         o_cal_start  <= cal_req;                                      // RULE_16
         if (cal_req)
            o_cal_type <= wr_data[B_CAL_FAM:B_CSEL_LO];                // RULE_15 RULE_18 RULE_19
         ctrl_wr_q    <= wr_ctrl;
         s_sleep      <= {s_sleep[0], i_sleep_n};
      end
   end

   // ----------------------------------------------------------------
   // pin outputs
   // ----------------------------------------------------------------
   // power mode code for the analog core: synced sleep pin, then bits 9:8
   assign o_power_sel = {s_sleep[1], ctrl[B_PM_HI:B_PM_LO]};           // RULE_10
   assign o_busy      = busy;
   assign o_dout      = ser.tx_bit;
   // in mode 1 the data input pin also carries the read word
   assign o_din_out   = ser.tx_bit;
   assign o_din_oe_n  = ~(mode1 & ser.tx_active);                      // RULE_11

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   ctrl_load_a: assert property (wr_ctrl |=> ctrl == $past(wr_data)) // RULE_08
      else $error("control word not loaded from frame");

   ctrl_hold_a: assert property (                                   // RULE_02
      !done |=> ctrl[B_PM_HI:B_RD_LO] == $past(ctrl[B_PM_HI:B_RD_LO])
                && ctrl[B_CAL_FAM:B_CSEL_LO] == $past(ctrl[B_CAL_FAM:B_CSEL_LO]))
      else $error("control field changed without a complete frame");

   null_addr_a: assert property (                                   // RULE_03
      done && wr_addr == ADDR_NONE |=> $stable(test)
                                      && ctrl[B_PM_HI:B_RD_LO] == $past(ctrl[B_PM_HI:B_RD_LO]))
      else $error("address 00 frame changed a register");

   test_wr_a: assert property (wr_test |=> test == $past(wr_data)) // RULE_03
      else $error("test register not written");

   conv_rd_a: assert property (                                     // RULE_07
      rd_sel == RD_CONV |-> ser.tx_word == {2'h0, i_conv_data})
      else $error("result word lacks leading zeros");

   // first bit on the pin after a frame opens on a result read
   conv_pin_a: assert property (                                    // RULE_07
      $rose(ser.tx_active) && $past(rd_sel) == RD_CONV |-> !o_dout)
      else $error("result read does not open with a zero bit");

   stat_rd_a: assert property (                                     // RULE_05
      rd_sel == RD_STAT |-> ser.tx_word[B_RD_HI:B_RD_LO] == RD_STAT
                            && ser.tx_word[14] == busy)
      else $error("status word malformed");

   mode_clr_a: assert property (                                    // RULE_12
      done && !wr_ctrl |=> !ctrl[B_MODE])
      else $error("interface mode bit not cleared after read");

   conv_clr_a: assert property (                                    // RULE_14
      i_conv_done && !wr_ctrl |=> !ctrl[B_CONV])
      else $error("conversion bit not cleared at completion");

   cal_go_a: assert property (                                      // RULE_16
      cal_req |=> o_cal_start && ctrl[B_CAL_START]
                  && o_cal_type == $past(wr_data[B_CAL_FAM:B_CSEL_LO]) ##1 !o_cal_start)
      else $error("calibration start pulse or type wrong");

   din_drive_a: assert property (                                   // RULE_11
      !o_din_oe_n |-> mode1 && o_din_out == o_dout)
      else $error("data input pin driven outside mode 1");
endmodule
`default_nettype wire

// *** tb/sadc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// host side of the serial link, sclk idles low
// ----------------------------------------------------------------
module sadc_host (
   input  wire logic i_clk,
   input  wire logic i_dout,
   input  wire logic i_din,
   output var logic  o_sclk,
   output var logic  o_sync_n,
   output var logic  o_din
);
   // din pin level at each sample point; in mode 1 the device drives it
   logic [15:0] din_seen;

   // idle levels at time zero
   initial begin
      o_sclk   = 1'b0;
      o_sync_n = 1'b1;
      o_din    = 1'b0;
   end

   // half an sclk period of 320 ns
   task automatic half();
      repeat (4) @(posedge i_clk);
   endtask

   // one frame, fewer than 16 bits aborts it; dout is taken just before each rise
   task automatic xfer(input logic [15:0] wr, input int nbits, output logic [15:0] rd);
      rd = 16'h0000;
      din_seen = 16'h0000;
      o_sync_n <= 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         o_din <= wr[i];
         half();
         rd[i] = i_dout;
         din_seen[i] = i_din;
         o_sclk <= 1'b1;
         half();
         o_sclk <= 1'b0;
      end
      half();
      o_sync_n <= 1'b1;
      // deselected: show the inverse so a stale bit is never mistaken for data
      o_din    <= ~o_din;
      repeat (8) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// *** tb/serial_adc_register_access_test.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// register access bench
// ----------------------------------------------------------------
module serial_adc_register_access_test;
   typedef struct packed {
      logic [15:0] wr;
      logic [15:0] rd;
   } sadc_row_t;
   logic        i_clk       = 1'b0;
   logic        i_nrst      = 1'b0;
   logic        i_sleep_n   = 1'b1;
   logic        i_conv_done = 1'b0;
   logic        i_cal_done  = 1'b0;
   logic [13:0] i_conv_data = 14'h2abc;
   wire logic   sclk;
   wire logic   sync_n;
   wire logic   host_din;
   wire logic   din_wire;
   logic        o_dout;
   logic        o_din_out;
   logic        o_din_oe_n;
   logic        o_conv_start;
   logic        o_cal_start;
   logic [2:0]  o_cal_type;
   logic [3:0]  o_cal_idx;
   logic [2:0]  o_power_sel;
   logic        o_busy;
   int          n_errors = 0;
   int          compares = 0;
   int          n_conv   = 0;
   int          n_cal    = 0;
   int          n_oe     = 0;
   int          oe0;
   logic [15:0] rd;
   // write word, word read back in the same frame
   sadc_row_t   rows [15] = '{
      '{16'h0000, 16'h2abc},
      '{16'h5234, 16'h2abc},
      '{16'hc040, 16'h2abc},
      '{16'h0000, 16'h1234},
      '{16'h0000, 16'h1234},
      '{16'hc2ce, 16'h1234},
      '{16'h0000, 16'h02ce},
      '{16'hc002, 16'h02ce},
      '{16'h8111, 16'h2abc},
      '{16'h8222, 16'h2abc},
      '{16'hc082, 16'h2abc},
      '{16'h0000, 16'h0111},
      '{16'h0000, 16'h0222},
      '{16'hc000, 16'h0111},
      '{16'h0000, 16'h2abc}
   };

   // din is shared: the device drives it only while its enable is low
   assign din_wire = o_din_oe_n ? host_din : o_din_out;

   always #20 i_clk = ~i_clk;

   // pulse and enable counters
   always @(posedge i_clk) begin
      if (o_conv_start === 1'b1) n_conv <= n_conv + 1;
      if (o_cal_start === 1'b1) n_cal <= n_cal + 1;
      if (o_din_oe_n === 1'b0) n_oe <= n_oe + 1;
   end

   sadc_host u_host (
      .i_clk    (i_clk),
      .i_dout   (o_dout),
      .i_din    (din_wire),
      .o_sclk   (sclk),
      .o_sync_n (sync_n),
      .o_din    (host_din)
   );

   sadc_regs u_dut (
      .i_clk           (i_clk),
      .i_nrst          (i_nrst),
      .i_sclk          (sclk),
      .i_sync_n        (sync_n),
      .i_din           (din_wire),
      .i_sleep_n       (i_sleep_n),
      .i_conv_data     (i_conv_data),
      .i_conv_done     (i_conv_done),
      .i_cal_done      (i_cal_done),
      .i_core_cal_we   (1'b0),
      .i_core_cal_idx  (4'h0),
      .i_core_cal_data (14'h0000),
      .o_dout          (o_dout),
      .o_din_out       (o_din_out),
      .o_din_oe_n      (o_din_oe_n),
      .o_conv_start    (o_conv_start),
      .o_cal_start     (o_cal_start),
      .o_cal_type      (o_cal_type),
      .o_cal_idx       (o_cal_idx),
      .o_power_sel     (o_power_sel),
      .o_busy          (o_busy)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic frame(input logic [15:0] wr, input logic [15:0] exp);
      u_host.xfer(wr, 16, rd);
      check(rd, exp);
   endtask

   // core completion pulse, busy must drop right after
   task automatic end_pulse(input logic conv);
      if (conv) begin
         i_conv_done <= 1'b1;
      end else begin
         i_cal_done <= 1'b1;
      end
      @(posedge i_clk);
      i_conv_done <= 1'b0;
      i_cal_done  <= 1'b0;
      repeat (2) @(posedge i_clk);
      check({15'h0, o_busy}, 16'h0000);
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      check({4'h0, o_busy, o_din_oe_n, o_cal_type, o_cal_idx, o_power_sel}, 16'h0404);
      for (int i = 0; i < 15; i++) begin
         frame(rows[i].wr, rows[i].rd);
      end
      // power field together with the sleep pin
      frame(16'hc300, 16'h2abc);
      i_sleep_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      check({13'h0, o_power_sel}, 16'h0003);
      i_sleep_n <= 1'b1;
      frame(16'hc000, 16'h2abc);
      // one conversion, one pulse, busy until done
      frame(16'hc010, 16'h2abc);
      check(16'(n_conv), 16'h0001);
      check({15'h0, o_busy}, 16'h0001);
      end_pulse(1'b1);
      // every calibration family and selector
      for (int t = 0; t < 8; t++) begin
         frame({2'b11, 10'h000, 3'(t), 1'b1}, 16'h2abc);
         check({13'h0, o_cal_type}, 16'(t));
         check({15'h0, o_busy}, 16'h0001);
         end_pulse(1'b0);
      end
      check(16'(n_cal), 16'h0008);
      // mode 1 holds for one read only, so a second read without a fresh write sees no drive
      frame(16'hc020, 16'h2abc);
      oe0 = n_oe;
      frame(16'h0000, 16'h2abc);
      check(u_host.din_seen, 16'h2abc);
      check(16'(n_oe > oe0), 16'h0001);
      oe0 = n_oe;
      frame(16'h0000, 16'h2abc);
      check(16'(n_oe - oe0), 16'h0000);
      // mid-run reset, then an aborted frame must write nothing
      frame(16'hc040, 16'h2abc);
      frame(16'h0000, 16'h1234);
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      frame(16'hc040, 16'h2abc);
      u_host.xfer(16'h7fff, 10, rd);
      frame(16'h0000, 16'h0000);
      give_verdict();
   end

   // watchdog, several times the expected run
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
